// ===== clc_decoder.sv
// Host bus instruction decoder with text and glyph memories and APB access.
`timescale 1ns/1ps
module clc_decoder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clc_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire clc_pkg::clc_host_in_t host_in,
    output clc_pkg::clc_host_out_t host_out,
    output clc_pkg::clc_cfg_t cfg
);
    import clc_pkg::*;

    // =========================================================================
    // State
    // =========================================================================
    clc_host_in_t sync1, sync2;
    clc_hstate_t hstate, next_hstate;
    clc_host_in_t latch, next_latch;
    clc_host_out_t next_host_out;
    clc_cfg_t next_cfg;
    logic nib_phase, next_nib_phase;
    logic [3:0] hi_nib, next_hi_nib;
    logic [6:0] pointer, next_pointer;
    logic glyph_sel, next_glyph_sel;
    logic step_up, next_step_up;
    logic [BUSY_W-1:0] busy_cnt, next_busy_cnt;
    logic [7:0] out_data, next_out_data;
    logic load1, next_load1;
    logic load2;
    logic [6:0] peek_addr, next_peek_addr;
    logic [7:0] glyph_code, next_glyph_code;
    logic [ROW_W-1:0] glyph_row, next_glyph_row;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    logic busy;
    logic text_we, glyph_we;
    logic [7:0] wbyte;
    logic [7:0] text_a_rdata, glyph_a_rdata;
    logic [7:0] text_b_rdata, glyph_b_rdata;
    logic [7:0] rd_byte, ex_byte;
    logic complete, access;

    assign busy = (busy_cnt != BUSY_IDLE);

    // =========================================================================
    // Memories
    // =========================================================================
    clc_dual_ram #(.AW(TEXT_AW), .DW(8)) u_text_mem (
        .pclk(pclk),
        .presetn(presetn),
        .a_we(text_we),
        .a_addr(pointer),
        .a_wdata(wbyte),
        .a_rdata(text_a_rdata),
        .b_addr(peek_addr),
        .b_rdata(text_b_rdata)
    );

    clc_dual_ram #(.AW(GLYPH_AW), .DW(8)) u_glyph_mem (
        .pclk(pclk),
        .presetn(presetn),
        .a_we(glyph_we),
        .a_addr(pointer[GLYPH_AW-1:0]),
        .a_wdata(wbyte),
        .a_rdata(glyph_a_rdata),
        .b_addr({glyph_code[ROW_W-1:0], glyph_row}),
        .b_rdata(glyph_b_rdata)
    );

    // =========================================================================
    // Host pin synchroniser
    // =========================================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= host_in;
            sync2 <= sync1;
        end
    end

    // =========================================================================
    // Host access and instruction execution
    // =========================================================================
    always_comb
    begin
        next_hstate = hstate;
        next_latch = latch;
        next_cfg = cfg;
        next_nib_phase = nib_phase;
        next_hi_nib = hi_nib;
        next_pointer = pointer;
        next_glyph_sel = glyph_sel;
        next_busy_cnt = busy ? busy_cnt - BUSY_DEC : busy_cnt;
        next_load1 = 1'b0;
        next_out_data = out_data;
        text_we = 1'b0;
        glyph_we = 1'b0;
        complete = cfg.bus_width_select | nib_phase;
        ex_byte = cfg.bus_width_select ? latch.db : {hi_nib, latch.db[7:4]};
        wbyte = ex_byte;

        // The read byte follows the live pins so that busy stays current.
        rd_byte = sync2.rs ? out_data : {busy, pointer};
        next_host_out.db_oe_n = ~(sync2.e & sync2.rw);
        if (cfg.bus_width_select)
            next_host_out.db_out = rd_byte;
        else if (!nib_phase)
            next_host_out.db_out = {rd_byte[7:4], 4'h0};
        else
            next_host_out.db_out = {rd_byte[3:0], 4'h0};

        // The pins are two flops late, so the data bus is latched while the
        // strobe is still high rather than at its falling edge.
        case (hstate)
            HS_IDLE:
            begin
                if (sync2.e)
                begin
                    next_latch = sync2;
                    next_hstate = HS_STROBE;
                end
            end
            HS_STROBE:
            begin
                if (sync2.e)
                    next_latch = sync2;
                else
                    next_hstate = HS_EXEC;
            end
            HS_EXEC:
            begin
                next_hstate = HS_IDLE;
                if (!cfg.bus_width_select)
                begin
                    next_nib_phase = ~nib_phase;
                    if (!nib_phase)
                        next_hi_nib = latch.db[7:4];
                end
                if (complete && !latch.rs && !latch.rw)
                begin
                    next_busy_cnt = BUSY_LOAD;
                    if (ex_byte[TEXT_ADDR_BIT])
                    begin
                        next_pointer = ex_byte[TEXT_AW-1:0];
                        next_glyph_sel = 1'b0;
                        next_load1 = 1'b1;
                    end
                    else if (ex_byte[7:6] == OP_GLYPH_ADDR)
                    begin
                        next_pointer = {1'b0, ex_byte[GLYPH_AW-1:0]};
                        next_glyph_sel = 1'b1;
                        next_load1 = 1'b1;
                    end
                    else if (ex_byte[7:5] == OP_FUNC_SET)
                    begin
                        next_cfg.bus_width_select = ex_byte[FN_WIDTH_BIT];
                        next_cfg.two_line = ex_byte[FN_LINES_BIT];
                        next_cfg.tall_font = ex_byte[FN_FONT_BIT];
                    end
                    else if (ex_byte[7:4] == OP_SHIFT && !ex_byte[SHIFT_SC_BIT])
                    begin
                        next_pointer = clc_ptr_step(pointer,
                            ex_byte[SHIFT_RL_BIT], cfg.two_line, glyph_sel);
                        // A display shift is not handled here; a cursor shift after a glyph
                        // address set steps the pointer and sets busy but does not reload.
                        next_load1 = ~glyph_sel;
                    end
                end
                else if (complete && latch.rs && !latch.rw)
                begin
                    text_we = ~glyph_sel;
                    glyph_we = glyph_sel;
                    // No reload: a following read sees the older word.
                    next_pointer = clc_ptr_step(pointer, step_up,
                        cfg.two_line, glyph_sel);
                    next_busy_cnt = BUSY_LOAD;
                end
                else if (complete && latch.rs && latch.rw)
                begin
                    next_pointer = clc_ptr_step(pointer, step_up,
                        cfg.two_line, glyph_sel);
                    next_load1 = 1'b1;
                    next_busy_cnt = BUSY_LOAD;
                end
            end
            default:
            begin
                next_hstate = HS_IDLE;
            end
        endcase

        // The output register holds whatever it last fetched, which is why
        // a read without an earlier address set gives stale data first.
        if (load2)
            next_out_data = glyph_sel ? glyph_a_rdata : text_a_rdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hstate <= HS_IDLE;
            latch <= '0;
            host_out.db_out <= 8'h00;
            host_out.db_oe_n <= 1'b1;
            cfg.bus_width_select <= BUS_WIDTH_RST;
            cfg.two_line <= TWO_LINE_RST;
            cfg.tall_font <= TALL_FONT_RST;
            nib_phase <= 1'b0;
            hi_nib <= 4'h0;
            pointer <= ADDR_FIRST;
            glyph_sel <= 1'b0;
            busy_cnt <= BUSY_IDLE;
            load1 <= 1'b0;
            load2 <= 1'b0;
            out_data <= 8'h00;
        end
        else
        begin
            hstate <= next_hstate;
            latch <= next_latch;
            host_out <= next_host_out;
            cfg <= next_cfg;
            nib_phase <= next_nib_phase;
            hi_nib <= next_hi_nib;
            pointer <= next_pointer;
            glyph_sel <= next_glyph_sel;
            busy_cnt <= next_busy_cnt;
            load1 <= next_load1;
            load2 <= load1;
            out_data <= next_out_data;
        end
    end

    // =========================================================================
    // APB register slave
    // =========================================================================
    always_comb
    begin
        access = psel & penable & ~pready;
        next_pready = access;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        next_step_up = step_up;
        next_peek_addr = peek_addr;
        next_glyph_code = glyph_code;
        next_glyph_row = glyph_row;
        if (access && pwrite)
        begin
            if (paddr == REG_CTRL)
                next_step_up = pwdata[CTRL_STEP_UP_BIT];
            else if (paddr == REG_TEXT_PEEK)
                next_peek_addr = pwdata[TEXT_AW-1:0];
            else if (paddr == REG_GLYPH_PEEK)
            begin
                next_glyph_code = pwdata[7:0];
                next_glyph_row = pwdata[10:8];
            end
            else if (paddr != REG_STATUS)
                next_pslverr = 1'b1;
        end
        else if (access)
        begin
            if (paddr == REG_CTRL)
                next_prdata = {31'h0, step_up};
            else if (paddr == REG_STATUS)
                next_prdata = {17'h0, pointer, hstate, nib_phase,
                               glyph_sel, cfg.tall_font, cfg.two_line,
                               cfg.bus_width_select, busy};
            else if (paddr == REG_TEXT_PEEK)
                next_prdata = {16'h0, text_b_rdata, 1'b0, peek_addr};
            else if (paddr == REG_GLYPH_PEEK)
                next_prdata = {7'h0, glyph_code[7:4] == USER_GLYPH_HI,
                               3'h0, glyph_b_rdata[PIXEL_W-1:0], 5'h0,
                               glyph_row, glyph_code};
            else
            begin
                next_prdata = 32'h0;
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            step_up <= STEP_UP_RST;
            peek_addr <= ADDR_FIRST;
            glyph_code <= 8'h00;
            glyph_row <= 3'h0;
        end
        else
        begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            step_up <= next_step_up;
            peek_addr <= next_peek_addr;
            glyph_code <= next_glyph_code;
            glyph_row <= next_glyph_row;
        end
    end

endmodule : clc_decoder

// ===== clc_decoder_properties.sv
// Checker for the host-side pins and configuration of the decoder.
`timescale 1ns/1ps
module clc_decoder_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire clc_pkg::clc_host_in_t host_in,
    input wire clc_pkg::clc_host_out_t host_out,
    input wire clc_pkg::clc_cfg_t cfg
);
    import clc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =========================================================
    // Host bus drive and configuration
    // =========================================================
    cfg_reset_val_a:
    assert property (!$past(presetn) |->
        cfg == {BUS_WIDTH_RST, TWO_LINE_RST, TALL_FONT_RST})
        else $error("cfg wrong after reset");
    cfg_by_instr_a:
    assert property ($changed(cfg) |->
        !host_in.e && !host_in.rs && !host_in.rw)
        else $error("cfg changed without instruction write");
    bus_idle_reset_a:
    assert property (!$past(presetn) |-> host_out.db_oe_n)
        else $error("bus driven after reset");
    read_drive_cause_a:
    assert property ($fell(host_out.db_oe_n) |->
        $past(host_in.e, 2) && $past(host_in.rw, 2))
        else $error("bus driven without read strobe");
    read_drive_soon_a:
    assert property ((host_in.e && host_in.rw) [*5] |->
        !host_out.db_oe_n)
        else $error("read strobe not answered");
    read_drive_hold_a:
    assert property (!host_out.db_oe_n && host_in.e && host_in.rw
        |=> !host_out.db_oe_n)
        else $error("bus dropped during read strobe");
    bus_release_a:
    assert property (!host_in.e [*5] |-> host_out.db_oe_n)
        else $error("bus not released after strobe");
    write_no_drive_a:
    assert property (!host_in.rw [*4] |-> host_out.db_oe_n)
        else $error("bus driven during write");
endmodule : clc_decoder_checker

bind clc_decoder clc_decoder_checker u_clc_decoder_checker (
    .pclk(pclk), .presetn(presetn), .host_in(host_in),
    .host_out(host_out), .cfg(cfg)
);

// ===== clc_decoder_tb_top.sv
// Self-checking bench for the character display decoder.
`timescale 1ns/1ps
module clc_decoder_tb_top;
    import clc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, q, st;
    logic [31:0] pwdata, prdata, rd;
    clc_host_in_t host_in;
    clc_host_out_t host_out;
    clc_cfg_t cfg;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    clc_decoder u_clc_decoder (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_in(host_in), .host_out(host_out),
        .cfg(cfg));
    clc_host_model u_clc_host_model (.pclk(pclk), .host_out(host_out),
        .host_in(host_in));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // =========================================================
    // Reporting
    // =========================================================
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask : check

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    // =========================================================
    // Bus tasks
    // =========================================================
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(n < 20, 1, "apb no ready");
    endtask : apb

    // The host waits for busy to clear before anything else.
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            u_clc_host_model.xfer(1'b0, 1'b1, 8'h00, st);
            n++;
        end
        while (st[7] !== 1'b0 && n < 1000);
        check(n < 1000, 1, "busy stuck");
    endtask : wait_idle

    task automatic op(input logic rs, input logic rw, input logic [7:0] d);
        u_clc_host_model.xfer(rs, rw, d, q);
        wait_idle();
    endtask : op

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic t_reset();
        check(cfg, 3'b100, "reset cfg");
        apb(REG_STATUS, 1'b0, 32'h0);
        check(rd[3:1], 3'b001, "status cfg");
        apb(8'h10, 1'b0, 32'h0);
        check(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        apb(REG_CTRL, 1'b1, 32'h1);
        $display("reset test done");
    endtask : t_reset

    task automatic t_text();
        op(1'b0, 1'b0, 8'h38);
        check(cfg, 3'b110, "two line cfg");
        u_clc_host_model.xfer(1'b0, 1'b0, 8'ha7, q);
        u_clc_host_model.xfer(1'b0, 1'b1, 8'h00, st);
        check(st, 8'ha7, "busy and pointer");
        wait_idle();
        op(1'b1, 1'b0, 8'h5a);
        check(st, 8'h40, "line wrap");
        op(1'b1, 1'b0, 8'h3c);
        op(1'b1, 1'b0, 8'h11);
        check(st, 8'h42, "write step");
        op(1'b0, 1'b0, 8'ha7);
        op(1'b1, 1'b1, 8'h00);
        check(q, 8'h5a, "data read");
        check(st, 8'h40, "read step");
        op(1'b1, 1'b0, 8'h77);
        op(1'b1, 1'b1, 8'h00);
        check(q, 8'h3c, "read after write");
        op(1'b0, 1'b0, 8'h10);
        op(1'b1, 1'b1, 8'h00);
        check(q, 8'h11, "shift reload");
        check(st, 8'h42, "shift step");
        apb(REG_TEXT_PEEK, 1'b1, 32'h40);
        apb(REG_TEXT_PEEK, 1'b0, 32'h0);
        check(rd[15:8], 8'h77, "text stored");
        $display("text test done");
    endtask : t_text

    task automatic t_glyph();
        apb(REG_CTRL, 1'b1, 32'h0);
        op(1'b0, 1'b0, 8'h48);
        check(st, 8'h08, "glyph pointer");
        op(1'b1, 1'b0, 8'hff);
        check(st, 8'h07, "step down");
        apb(REG_GLYPH_PEEK, 1'b1, 32'h9);
        apb(REG_GLYPH_PEEK, 1'b0, 32'h0);
        check({rd[24], rd[20:16]}, 6'h3f, "glyph pixels");
        apb(REG_CTRL, 1'b1, 32'h1);
        $display("glyph test done");
    endtask : t_glyph

    task automatic t_nibble();
        // The host must switch before polling, or the nibble phase drifts.
        u_clc_host_model.xfer(1'b0, 1'b0, 8'h24, q);
        u_clc_host_model.four_bit = 1'b1;
        wait_idle();
        check(cfg, 3'b001, "nibble cfg");
        op(1'b0, 1'b0, 8'hcf);
        check(st, 8'h4f, "nibble pointer");
        op(1'b1, 1'b0, 8'h66);
        check(st, 8'h00, "one line wrap");
        apb(REG_TEXT_PEEK, 1'b1, 32'h4f);
        apb(REG_TEXT_PEEK, 1'b0, 32'h0);
        check(rd[15:8], 8'h66, "nibble data");
        apb(REG_CTRL, 1'b1, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        u_clc_host_model.four_bit = 1'b0;
        @(posedge pclk);
        check(cfg, 3'b100, "cfg after reset");
        apb(REG_CTRL, 1'b0, 32'h0);
        check(rd, 32'h1, "step after reset");
        $display("nibble test done");
    endtask : t_nibble

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_text();
        t_glyph();
        t_nibble();
        summarize();
    end
endmodule : clc_decoder_tb_top

// ===== clc_dual_ram.sv
// Small two-port memory with registered read data on both ports.
`timescale 1ns/1ps
module clc_dual_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_wdata,
    output logic [DW-1:0] a_rdata,
    input wire logic [AW-1:0] b_addr,
    output logic [DW-1:0] b_rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge pclk)
    begin
        if (a_we)
            mem[a_addr] <= a_wdata;
    end

    // Read-before-write on port A: the old word is returned on a write cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_rdata <= '0;
            b_rdata <= '0;
        end
        else
        begin
            a_rdata <= mem[a_addr];
            b_rdata <= mem[b_addr];
        end
    end

endmodule : clc_dual_ram

// ===== clc_host_model.sv
// Behavioural host processor on the parallel display bus.
`timescale 1ns/1ps
module clc_host_model (
    input wire logic pclk,
    input wire clc_pkg::clc_host_out_t host_out,
    output clc_pkg::clc_host_in_t host_in
);
    import clc_pkg::*;
    logic four_bit = 1'b0;
    initial host_in = '0;
    // =========================================================
    // Strobes
    // =========================================================
    // Data lines are held three edges past the strobe so the device's
    // synchroniser still samples them; then they are scrambled.
    task automatic strobe(input logic rs, input logic rw,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge pclk);
        host_in <= '{e: 1'b1, rs: rs, rw: rw, db: rw ? ~host_in.db : d};
        repeat (6) @(posedge pclk);
        q = host_out.db_out;
        host_in.e <= 1'b0;
        repeat (3) @(posedge pclk);
        host_in.db <= ~host_in.db;
        repeat (3) @(posedge pclk);
    endtask : strobe
    // Reads need not follow an address set, so a first read after a data write is stale.
    task automatic xfer(input logic rs, input logic rw,
                        input logic [7:0] d, output logic [7:0] q);
        logic [7:0] h;
        logic [7:0] l;
        if (four_bit)
        begin
            strobe(rs, rw, {d[7:4], 4'h0}, h);
            strobe(rs, rw, {d[3:0], 4'h0}, l);
            q = {h[7:4], l[7:4]};
        end
        else
            strobe(rs, rw, d, q);
    endtask : xfer
endmodule : clc_host_model

// ===== clc_pkg.sv
// Shared constants, types and helpers for the character display decoder.
package clc_pkg;

    // =========================================================================
    // Timing
    // =========================================================================
    localparam int CLK_MHZ = 100;
    localparam int BUSY_NS = 38000;
    localparam int BUSY_CYCLES = (BUSY_NS * CLK_MHZ + 999) / 1000;
    localparam int BUSY_W = 12;
    localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY_CYCLES);
    localparam logic [BUSY_W-1:0] BUSY_IDLE = 12'h000;
    localparam logic [BUSY_W-1:0] BUSY_DEC = 12'h001;

    // =========================================================================
    // Memories and address ranges
    // =========================================================================
    localparam int TEXT_AW = 7;
    localparam int GLYPH_AW = 6;
    localparam int ROW_W = 3;
    localparam int PIXEL_W = 5;
    localparam logic [6:0] ADDR_FIRST = 7'h00;
    localparam logic [6:0] ADDR_ONE = 7'h01;
    localparam logic [6:0] SINGLE_LAST = 7'h4f;
    localparam logic [6:0] LINE1_LAST = 7'h27;
    localparam logic [6:0] LINE2_FIRST = 7'h40;
    localparam logic [6:0] LINE2_LAST = 7'h67;
    localparam logic [3:0] USER_GLYPH_HI = 4'h0;

    // =========================================================================
    // Instruction decode
    // =========================================================================
    localparam logic [2:0] OP_FUNC_SET = 3'h1;
    localparam logic [1:0] OP_GLYPH_ADDR = 2'h1;
    localparam logic [3:0] OP_SHIFT = 4'h1;
    localparam int FN_WIDTH_BIT = 4;
    localparam int FN_LINES_BIT = 3;
    localparam int FN_FONT_BIT = 2;
    localparam int SHIFT_SC_BIT = 3;
    localparam int SHIFT_RL_BIT = 2;
    localparam int TEXT_ADDR_BIT = 7;

    // =========================================================================
    // Register map and reset values
    // =========================================================================
    localparam int PADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TEXT_PEEK = 8'h08;
    localparam logic [7:0] REG_GLYPH_PEEK = 8'h0c;
    localparam int CTRL_STEP_UP_BIT = 0;
    localparam logic STEP_UP_RST = 1'b1;
    localparam logic BUS_WIDTH_RST = 1'b1;
    localparam logic TWO_LINE_RST = 1'b0;
    localparam logic TALL_FONT_RST = 1'b0;

    // =========================================================================
    // Types
    // =========================================================================
    typedef struct packed {
        logic e;
        logic rs;
        logic rw;
        logic [7:0] db;
    } clc_host_in_t;

    typedef struct packed {
        logic [7:0] db_out;
        logic db_oe_n;
    } clc_host_out_t;

    typedef struct packed {
        logic bus_width_select;
        logic two_line;
        logic tall_font;
    } clc_cfg_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_STROBE = 2'b01,
        HS_EXEC = 2'b11
    } clc_hstate_t;

    // Steps the pointer one place, wrapping inside the active text ranges or, for glyph memory, inside the glyph range.
    function automatic logic [6:0] clc_ptr_step(input logic [6:0] a,
                                                input logic up,
                                                input logic two,
                                                input logic glyph);
        logic [6:0] r;
        r = up ? a + ADDR_ONE : a - ADDR_ONE;
        if (glyph)
        begin
            r = {1'b0, r[GLYPH_AW-1:0]};
        end
        else if (two)
        begin
            if (up && a == LINE1_LAST)
                r = LINE2_FIRST;
            else if (up && a == LINE2_LAST)
                r = ADDR_FIRST;
            else if (!up && a == LINE2_FIRST)
                r = LINE1_LAST;
            else if (!up && a == ADDR_FIRST)
                r = LINE2_LAST;
        end
        else
        begin
            if (up && a == SINGLE_LAST)
                r = ADDR_FIRST;
            else if (!up && a == ADDR_FIRST)
                r = SINGLE_LAST;
        end
        return r;
    endfunction : clc_ptr_step

endpackage : clc_pkg
